//--- rtl/core_regs_pkg.sv
// What this block does
// RQ1: One 8-bit accumulator holds operands and results.
// RQ2: Two 8-bit index registers serve addressing or temporary data.
// RQ3: A prefix opcode makes the next instruction use the second index register.
// RQ4: Interrupt context save and restore never touch the second index register.
// RQ5: Program counter is 16 bits, built from low and high byte registers.
// RQ6: Condition register holds mask plus four flags; push and pop save it.
// RQ7: Add and add-with-carry set half-carry on carry out of bit 3, else clear.
// RQ8: Entering interrupt service sets the mask bit, bit 3.
// RQ9: Mask set blocks maskable interrupts; the software trap still gets in.
// RQ10: Clear-mask clears, set-mask sets, interrupt return clears the mask bit.
// RQ11: Requests arriving while masked stay pending until the mask clears.
// RQ12: Clearing the mask inside a service routine takes pending requests at once.
// RQ13: Negative flag copies result bit 7 after every data operation.
// RQ14: Zero flag is one exactly when the data operation result is zero.
// RQ15: Carry flag, bit 0, shows overflow or underflow of the last arithmetic.
// RQ16: Set-carry forces carry to one, reset-carry forces it to zero.
// RQ17: Bit-test-and-branch, shift and rotate also update the carry flag.
// RQ18: Branches test each flag with true and false forms.
// RQ19: Flags written back with the result, visible to the next branch.
package core_regs_pkg;

	localparam int          DATA_W       = 8;
	localparam int          PC_W         = 16;
	localparam int          IRQ_W        = 8;
	localparam int          FLAG_C       = 0;
	localparam int          FLAG_Z       = 1;
	localparam int          FLAG_N       = 2;
	localparam int          FLAG_I       = 3;
	localparam int          FLAG_H       = 4;
	localparam int          NIBBLE_W     = 4;
	localparam logic [7:0]  FLAGS_RESET  = 8'hE8;
	localparam logic [7:0]  FLAGS_RSVD   = 8'hE0;
	localparam logic [7:0]  ZERO_BYTE    = 8'h00;
	localparam logic [15:0] PC_RESET     = 16'h0000;

	// Operation issued by the decoder in one cycle
	typedef enum logic [3:0] {
		OP_NONE, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_LOGIC, OP_LOAD, OP_SHIFT,
		OP_BTJ, OP_SCF, OP_RCF, OP_SIM, OP_RIM, OP_POPCC, OP_INTERRUPT_RETURN_INSTR
	} op_t;

	// Register destination of a write-back
	typedef enum logic [1:0] {
		DST_NONE, DST_ACC, DST_INDEX
	} dst_t;

	// Branch condition selector
	typedef enum logic [3:0] {
		BR_H, BR_NH, BR_M, BR_NM, BR_MI, BR_PL, BR_EQ, BR_NE, BR_C, BR_NC
	} br_t;

	// One instruction step from the decoder and ALU
	typedef struct packed {
		op_t        op;
		dst_t       dst;
		logic       prefix;
		logic [7:0] opa;
		logic [7:0] opb;
		logic [7:0] result;
		logic       shift_c;
	} exec_t;

	// Program counter load request
	typedef struct packed {
		logic        load_low;
		logic        load_high;
		logic        incr;
		logic [15:0] value;
	} pc_req_t;

endpackage

//--- rtl/core_regs.sv
module core_regs #(
	parameter int IRQ_LINES = core_regs_pkg::IRQ_W
) (
	input  wire logic                           clock,
	input  wire logic                           rst_n,
	input  wire logic                           clk_en,
	input  wire core_regs_pkg::exec_t           exec,
	input  wire core_regs_pkg::pc_req_t         pc_req,
	input  wire logic                           prefix_seen,
	input  wire logic                           irq_enter,
	input  wire logic                           trap_req,
	input  wire logic [IRQ_LINES-1:0]           irq_lines,
	input  wire logic [IRQ_LINES-1:0]           irq_ack,
	input  wire core_regs_pkg::br_t             br_sel,
	output logic [7:0]                          accumulator_q,
	output logic [7:0]                          index_first_q,
	output logic [7:0]                          index_second_q,
	output logic [15:0]                         program_counter_q,
	output logic [7:0]                          condition_flags_q,
	output logic                                prefix_q,
	output logic [IRQ_LINES-1:0]                pending_q,
	output logic                                irq_take_q,
	output logic                                branch_take_q
);
	import core_regs_pkg::*;

	// Program counter advance per sequential fetch
	localparam logic [15:0] PC_STEP = 16'h0001;

	// Refuse request widths that the pending latch cannot hold
	if (IRQ_LINES < 1 || IRQ_LINES > 32) begin : g_bad_lines
		$error("IRQ_LINES must lie between 1 and 32");
	end

	// Operation decode
	wire is_add   = (exec.op == OP_ADD) || (exec.op == OP_ADC);
	wire is_sub   = (exec.op == OP_SUB) || (exec.op == OP_SBC);
	wire is_data  = is_add || is_sub || (exec.op == OP_LOGIC) ||
	                (exec.op == OP_LOAD) || (exec.op == OP_SHIFT);
	wire carry_in = ((exec.op == OP_ADC) || (exec.op == OP_SBC)) &&
	                condition_flags_q[FLAG_C];

	// Carry chain on 9 bits, the half-carry on the low nibble
	wire [8:0] add_sum = {1'b0, exec.opa} + {1'b0, exec.opb} + {8'h00, carry_in};
	wire [8:0] sub_dif = {1'b0, exec.opa} - {1'b0, exec.opb} - {8'h00, carry_in};
	wire [4:0] nib_sum = {1'b0, exec.opa[NIBBLE_W-1:0]} + {1'b0, exec.opb[NIBBLE_W-1:0]}
	                     + {4'h0, carry_in};

	// Flag next values
	logic [7:0] flags_d;
	always_comb begin
		flags_d = condition_flags_q;
		if (is_add)
			flags_d[FLAG_H] = nib_sum[NIBBLE_W]; // RQ7
		if (is_data) begin
			flags_d[FLAG_N] = exec.result[DATA_W-1]; // RQ13
			flags_d[FLAG_Z] = (exec.result == ZERO_BYTE); // RQ14
		end
		if (is_add)
			flags_d[FLAG_C] = add_sum[DATA_W]; // RQ15
		else if (is_sub)
			flags_d[FLAG_C] = sub_dif[DATA_W]; // RQ15
		else if ((exec.op == OP_SHIFT) || (exec.op == OP_BTJ))
			flags_d[FLAG_C] = exec.shift_c; // RQ17
		else if (exec.op == OP_SCF)
			flags_d[FLAG_C] = 1'b1; // RQ16
		else if (exec.op == OP_RCF)
			flags_d[FLAG_C] = 1'b0; // RQ16
		if (exec.op == OP_SIM)
			flags_d[FLAG_I] = 1'b1; // RQ10
		else if ((exec.op == OP_RIM) || (exec.op == OP_INTERRUPT_RETURN_INSTR))
			flags_d[FLAG_I] = 1'b0; // RQ10
		if (exec.op == OP_POPCC)
			flags_d = exec.result | FLAGS_RSVD; // RQ6
		// Entry wins over any software change of the mask bit in the same cycle
		if (irq_enter)
			flags_d[FLAG_I] = 1'b1; // RQ8
		flags_d = flags_d | FLAGS_RSVD;
	end

	// Index selection follows the step's own prefix or the prefix captured one instruction earlier
	wire use_second = exec.prefix || prefix_q; // RQ3
	wire wr_acc     = exec.dst == DST_ACC;
	wire wr_first   = (exec.dst == DST_INDEX) && !use_second;
	wire wr_second  = (exec.dst == DST_INDEX) && use_second;

	// Pending requests, set wins over acknowledge
	wire [IRQ_LINES-1:0] pending_d = (pending_q & ~irq_ack) | irq_lines; // RQ11
	wire                 any_pend  = |pending_q;

	// Branch condition on the live flags
	logic br_d;
	always_comb begin
		case (br_sel)
			BR_H:    br_d = condition_flags_q[FLAG_H]; // RQ18
			BR_NH:   br_d = !condition_flags_q[FLAG_H];
			BR_M:    br_d = condition_flags_q[FLAG_I];
			BR_NM:   br_d = !condition_flags_q[FLAG_I];
			BR_MI:   br_d = condition_flags_q[FLAG_N];
			BR_PL:   br_d = !condition_flags_q[FLAG_N];
			BR_EQ:   br_d = condition_flags_q[FLAG_Z];
			BR_NE:   br_d = !condition_flags_q[FLAG_Z];
			BR_C:    br_d = condition_flags_q[FLAG_C];
			BR_NC:   br_d = !condition_flags_q[FLAG_C];
			default: br_d = 1'b0;
		endcase
	end

	// Take decision ignores the routine's own priority once mask is low
	wire take_d = trap_req || (any_pend && !condition_flags_q[FLAG_I]); // RQ9 RQ12

	// Program counter byte halves load separately
	logic [15:0] pc_d;
	always_comb begin
		pc_d = program_counter_q;
		if (pc_req.incr)
			pc_d = program_counter_q + PC_STEP;
		if (pc_req.load_low)
			pc_d[7:0] = pc_req.value[7:0]; // RQ5
		if (pc_req.load_high)
			pc_d[15:8] = pc_req.value[15:8]; // RQ5
	end

	// Condition register and pending latch
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			condition_flags_q <= FLAGS_RESET;
			pending_q         <= '0;
		end else if (clk_en) begin
			condition_flags_q <= flags_d; // RQ19
			pending_q         <= pending_d;
		end
	end

	// Data registers; no interrupt path writes the second index
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			accumulator_q  <= ZERO_BYTE;
			index_first_q  <= ZERO_BYTE;
			index_second_q <= ZERO_BYTE;
		end else if (clk_en) begin
			if (wr_acc)
				accumulator_q <= exec.result; // RQ1
			if (wr_first)
				index_first_q <= exec.result; // RQ2
			if (wr_second && !irq_enter && exec.op != OP_INTERRUPT_RETURN_INSTR)
				index_second_q <= exec.result; // RQ4
		end
	end

	// Prefix capture, program counter and decisions
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prefix_q          <= 1'b0;
			program_counter_q <= PC_RESET;
			irq_take_q        <= 1'b0;
			branch_take_q     <= 1'b0;
		end else if (clk_en) begin
			prefix_q          <= prefix_seen;
			program_counter_q <= pc_d;
			irq_take_q        <= take_d;
			branch_take_q     <= br_d;
		end
	end

	// Checks
	AST_HALF_CARRY: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
		clk_en && is_add |=> condition_flags_q[FLAG_H] == $past(nib_sum[NIBBLE_W]))
		else $error("half carry not loaded from nibble carry");
	AST_MASK_ENTRY: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
		clk_en && irq_enter |=> condition_flags_q[FLAG_I])
		else $error("mask not set on interrupt entry");
	AST_MASK_BLOCK: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
		clk_en && condition_flags_q[FLAG_I] && !trap_req |=> !irq_take_q)
		else $error("maskable interrupt taken while masked");
	AST_TRAP: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
		clk_en && trap_req |=> irq_take_q)
		else $error("trap not accepted");
	AST_MASK_SW: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
		clk_en && !irq_enter && (exec.op == OP_RIM || exec.op == OP_INTERRUPT_RETURN_INSTR)
		|=> !condition_flags_q[FLAG_I])
		else $error("mask not cleared by software");
	AST_PENDING: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
		clk_en && irq_lines[0] |=> pending_q[0])
		else $error("request not latched");
	AST_UNMASK_TAKE: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
		clk_en && $fell(condition_flags_q[FLAG_I]) && any_pend |=> irq_take_q)
		else $error("pending request not taken after unmask");
	AST_NEG_ZERO: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
		clk_en && is_data && !irq_enter |=> condition_flags_q[FLAG_N] ==
		$past(exec.result[DATA_W-1]) &&
		condition_flags_q[FLAG_Z] == ($past(exec.result) == ZERO_BYTE))
		else $error("sign or zero flag wrong");
	AST_CARRY_SET: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
		clk_en && exec.op == OP_SCF |=> condition_flags_q[FLAG_C])
		else $error("set carry failed");
	AST_SECOND_KEEP: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
		irq_enter |=> $stable(index_second_q))
		else $error("second index changed on interrupt entry");
	AST_RSVD: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
		(condition_flags_q & FLAGS_RSVD) == FLAGS_RSVD)
		else $error("reserved flag bits not set");

	// Accumulator takes the result it was handed
	AST_ACC_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
		clk_en && wr_acc |=> accumulator_q == $past(exec.result))
		else $error("accumulator write lost");

	// Accumulator keeps its value when no step names it
	AST_ACC_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RQ1
		clk_en && !wr_acc |=> $stable(accumulator_q))
		else $error("accumulator changed without a write");

	// First index takes an unprefixed index write
	AST_FIRST_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // RQ2
		clk_en && wr_first |=> index_first_q == $past(exec.result))
		else $error("first index write lost");

	// Prefixed steps must leave the first index alone
	AST_FIRST_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
		clk_en && use_second |=> $stable(index_first_q))
		else $error("first index written by a prefixed step");

	// Prefixed write outside interrupt sequencing reaches the second index
	AST_SECOND_SELECT: assert property (@(posedge clock) disable iff (!rst_n) // RQ3
		clk_en && wr_second && !irq_enter && exec.op != OP_INTERRUPT_RETURN_INSTR
		|=> index_second_q == $past(exec.result))
		else $error("second index write lost");

	// Return from interrupt restores context but never the second index
	AST_SECOND_INTERRUPT_RETURN_INSTR: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
		clk_en && exec.op == OP_INTERRUPT_RETURN_INSTR |=> $stable(index_second_q))
		else $error("second index changed on interrupt return");

	// Second index keeps its value when no step names it
	AST_SECOND_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RQ4
		clk_en && !wr_second |=> $stable(index_second_q))
		else $error("second index changed without a write");

	// Low byte load lands in the low half only
	AST_PC_LOW: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		clk_en && pc_req.load_low
		|=> program_counter_q[7:0] == $past(pc_req.value[7:0]))
		else $error("program counter low byte not loaded");

	// High byte load lands in the high half only
	AST_PC_HIGH: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		clk_en && pc_req.load_high
		|=> program_counter_q[15:8] == $past(pc_req.value[15:8]))
		else $error("program counter high byte not loaded");

	// Sequential fetch carries across the byte boundary
	AST_PC_INCR: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		clk_en && pc_req.incr && !pc_req.load_low && !pc_req.load_high
		|=> program_counter_q == $past(program_counter_q) + PC_STEP)
		else $error("program counter did not advance");

	// No request, no movement of the program counter
	AST_PC_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // RQ5
		clk_en && !pc_req.incr && !pc_req.load_low && !pc_req.load_high
		|=> $stable(program_counter_q))
		else $error("program counter moved without a request");

	// Pop restores every flag; reserved bits come back set whatever was stacked
	AST_POP_FLAGS: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
		clk_en && exec.op == OP_POPCC && !irq_enter
		|=> condition_flags_q == ($past(exec.result) | FLAGS_RSVD))
		else $error("flags not restored by pop");

	// Only add forms and a pop may touch the half-carry
	AST_HALF_KEEP: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
		clk_en && !is_add && exec.op != OP_POPCC |=> $stable(condition_flags_q[FLAG_H]))
		else $error("half carry changed by a non-add step");

	// Set-mask raises the mask bit
	AST_MASK_SET: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
		clk_en && exec.op == OP_SIM |=> condition_flags_q[FLAG_I])
		else $error("mask not set by software");

	// Nothing pending and no trap means nothing taken
	AST_NO_TAKE_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // RQ9
		clk_en && !trap_req && !any_pend |=> !irq_take_q)
		else $error("interrupt taken with nothing pending");

	// Acknowledge without a new request clears the pending bit
	AST_PENDING_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
		clk_en && irq_ack[0] && !irq_lines[0] |=> !pending_q[0])
		else $error("pending request not cleared by acknowledge");

	// Add carry is the ninth bit of the full sum, carry in included
	AST_CARRY_ADD: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
		clk_en && is_add |=> condition_flags_q[FLAG_C] == $past(add_sum[DATA_W]))
		else $error("carry not loaded from add");

	// Subtract carry is the borrow out of the top bit
	AST_CARRY_SUB: assert property (@(posedge clock) disable iff (!rst_n) // RQ15
		clk_en && is_sub |=> condition_flags_q[FLAG_C] == $past(sub_dif[DATA_W]))
		else $error("borrow not loaded from subtract");

	// Reset-carry forces the carry low
	AST_CARRY_CLEAR: assert property (@(posedge clock) disable iff (!rst_n) // RQ16
		clk_en && exec.op == OP_RCF |=> !condition_flags_q[FLAG_C])
		else $error("reset carry failed");

	// Shift and bit test hand their own carry bit over
	AST_CARRY_SHIFT: assert property (@(posedge clock) disable iff (!rst_n) // RQ17
		clk_en && (exec.op == OP_SHIFT || exec.op == OP_BTJ)
		|=> condition_flags_q[FLAG_C] == $past(exec.shift_c))
		else $error("carry not loaded from shift or bit test");

	// Carry branch follows the carry flag as it stood at decision time
	AST_BRANCH_CARRY: assert property (@(posedge clock) disable iff (!rst_n) // RQ18
		clk_en && br_sel == BR_C |=> branch_take_q == $past(condition_flags_q[FLAG_C]))
		else $error("carry branch decision wrong");

	// Not-equal branch is the inverse of the zero flag
	AST_BRANCH_NE: assert property (@(posedge clock) disable iff (!rst_n) // RQ18
		clk_en && br_sel == BR_NE |=> branch_take_q == !$past(condition_flags_q[FLAG_Z]))
		else $error("not-equal branch decision wrong");

	// A low enable freezes every register, flags included
	AST_FREEZE: assert property (@(posedge clock) disable iff (!rst_n) // RQ19
		!clk_en |=> $stable(condition_flags_q) && $stable(program_counter_q) &&
		$stable(accumulator_q) && $stable(pending_q))
		else $error("state moved while the clock enable was low");

	COV_TAKE:   cover property (@(posedge clock) disable iff (!rst_n) irq_take_q);
	COV_PREFIX: cover property (@(posedge clock) disable iff (!rst_n) clk_en && wr_second);
	COV_HALF:   cover property (@(posedge clock) disable iff (!rst_n)
		clk_en && is_add && nib_sum[NIBBLE_W]);
	COV_BRANCH: cover property (@(posedge clock) disable iff (!rst_n) branch_take_q);
	COV_POP:    cover property (@(posedge clock) disable iff (!rst_n)
		clk_en && exec.op == OP_POPCC);

endmodule

//--- verification/alu_model.sv
// Decoder and ALU stand-in: turns an operation and operands into one step
module alu_model
	import core_regs_pkg::*;
(
	input  wire op_t        op,
	input  wire dst_t       dst,
	input  wire logic       pre,
	input  wire logic [7:0] a,
	input  wire logic [7:0] b,
	input  wire logic       cin,
	output exec_t           exec
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [8:0] sum_w;
	logic [7:0] res_w;
	logic       sub_w;
	// Carry in only for the with-carry forms; shifts go left, bit 7 leaves
	assign sub_w = (op == OP_SUB) || (op == OP_SBC);
	assign sum_w = sub_w ? {1'b0, a} - {1'b0, b} - 9'(op == OP_SBC && cin)
		: {1'b0, a} + {1'b0, b} + 9'(op == OP_ADC && cin);
	assign res_w = (op == OP_LOGIC) ? (a & b) : (op == OP_LOAD) ? b
		: (op == OP_SHIFT) ? {a[6:0], 1'b0} : sum_w[7:0];
	assign exec = '{op, dst, pre, a, b, res_w, a[7]};
endmodule

//--- verification/cpu_core_regs_condition_flags_test.sv
module cpu_core_regs_condition_flags_test;
	import core_regs_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock, rst_n, clk_en, pre, prefix_seen, irq_enter, trap_req;
	logic [7:0] a, b, irq_lines, irq_ack, acc, ix1, ix2, flags, pend, ef;
	logic [15:0] pc;
	logic       pfx, take, br_take;
	op_t        op;
	dst_t       dst;
	br_t        br_sel;
	pc_req_t    pc_req;
	exec_t      exec;
	int         fails, check_count;
	logic [7:0] ta [4] = '{8'h0F, 8'hF0, 8'h80, 8'h7F};
	logic [7:0] tb [4] = '{8'h01, 8'h20, 8'h80, 8'h01};
	logic [8:0] s;

	alu_model alu_model_inst (.op(op), .dst(dst), .pre(pre), .a(a), .b(b),
		.cin(flags[0]), .exec(exec));
	core_regs core_regs_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.exec(exec), .pc_req(pc_req), .prefix_seen(prefix_seen),
		.irq_enter(irq_enter), .trap_req(trap_req), .irq_lines(irq_lines),
		.irq_ack(irq_ack), .br_sel(br_sel), .accumulator_q(acc),
		.index_first_q(ix1), .index_second_q(ix2), .program_counter_q(pc),
		.condition_flags_q(flags), .prefix_q(pfx), .pending_q(pend),
		.irq_take_q(take), .branch_take_q(br_take));

	// 20 MHz core clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One clock edge; single-cycle pulses drop back afterwards
	task automatic step(input op_t o, input dst_t d, input logic p,
		input logic [7:0] x, input logic [7:0] y);
		op = o; dst = d; pre = p; a = x; b = y;
		@(posedge clock);
		#1;
		op = OP_NONE; dst = DST_NONE; pre = 1'b0; irq_enter = 1'b0; trap_req = 1'b0;
		irq_lines = 8'h00; irq_ack = 8'h00; pc_req = '0; prefix_seen = 1'b0;
	endtask

	task automatic tick;
		step(OP_NONE, DST_NONE, 1'b0, 8'h00, 8'h00);
	endtask

	task automatic results;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog: the sequence needs well under 200 cycles
	initial begin
		#100000;
		fails++;
		results();
	end

	initial begin
		fails = 0; check_count = 0; rst_n = 1'b0; clk_en = 1'b1; br_sel = BR_H;
		op = OP_NONE; dst = DST_NONE; pre = 1'b0; a = 8'h00; b = 8'h00;
		irq_enter = 1'b0; trap_req = 1'b0; irq_lines = 8'h00; irq_ack = 8'h00;
		pc_req = '0; prefix_seen = 1'b0;
		repeat (6) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(flags, 16'h00E8);
		chk(pc, 16'h0000);
		// Adds across half-carry, carry, zero and sign boundaries
		for (int k = 0; k < 4; k++) begin
			step(OP_ADD, DST_ACC, 1'b0, ta[k], tb[k]);
			s = {1'b0, ta[k]} + {1'b0, tb[k]};
			ef = {3'b111, ({1'b0, ta[k][3:0]} + {1'b0, tb[k][3:0]}) > 5'h0F, 1'b1,
				s[7], s[7:0] == 8'h00, s[8]};
			chk(acc, s[7:0]);
			chk(flags, ef);
		end
		step(OP_SUB, DST_ACC, 1'b0, 8'h00, 8'h01);
		chk(flags & 8'h07, 16'h0005);
		step(OP_SBC, DST_ACC, 1'b0, 8'h05, 8'h01);
		chk(acc, 16'h0003);
		chk(flags[0], 1'b0);
		step(OP_LOGIC, DST_ACC, 1'b0, 8'hF0, 8'h0F);
		chk(flags & 8'h06, 16'h0002);
		step(OP_SCF, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[0], 1'b1);
		step(OP_ADC, DST_ACC, 1'b0, 8'h0F, 8'h00);
		chk(acc, 16'h0010);
		chk(flags[4], 1'b1);
		step(OP_RCF, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[0], 1'b0);
		// Shift pushes bit 7 into carry; half-carry left by the last add
		step(OP_SHIFT, DST_ACC, 1'b0, 8'h80, 8'h00);
		ef = 8'hFB;
		chk(flags, ef);
		// Every branch condition, true and false forms, one cycle late
		for (int k = 0; k < 10; k++) begin
			br_sel = br_t'(k);
			tick;
			chk(br_take, ef[4 - k / 2] ^ k[0]);
		end
		step(OP_BTJ, DST_NONE, 1'b0, 8'h01, 8'h00);
		chk(flags[0], 1'b0);
		// Masked request stays pending; the trap still gets through
		irq_lines = 8'h01;
		tick;
		chk(pend[0], 1'b1);
		tick;
		chk(take, 1'b0);
		trap_req = 1'b1;
		tick;
		chk(take, 1'b1);
		step(OP_RIM, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[3], 1'b0);
		tick;
		chk(take, 1'b1);
		// Entry with a second-index write in the same cycle: write dropped
		irq_enter = 1'b1;
		irq_ack = 8'h01;
		step(OP_LOAD, DST_INDEX, 1'b1, 8'h00, 8'h55);
		chk(ix2, 8'h00);
		chk(flags[3], 1'b1);
		chk(pend[0], 1'b0);
		step(OP_INTERRUPT_RETURN_INSTR, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[3], 1'b0);
		step(OP_SIM, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[3], 1'b1);
		step(OP_LOAD, DST_INDEX, 1'b1, 8'h00, 8'hA5);
		chk(ix2, 8'hA5);
		step(OP_LOAD, DST_INDEX, 1'b0, 8'h00, 8'h5A);
		chk(ix1, 8'h5A);
		prefix_seen = 1'b1;
		tick;
		chk(pfx, 1'b1);
		step(OP_LOAD, DST_INDEX, 1'b0, 8'h00, 8'hC3);
		chk(ix2, 8'hC3);
		// Low and high bytes load on their own, then count up
		pc_req = '{1'b1, 1'b0, 1'b0, 16'h1234};
		tick;
		chk(pc, 16'h0034);
		pc_req = '{1'b0, 1'b1, 1'b0, 16'h1234};
		tick;
		chk(pc, 16'h1234);
		pc_req = '{1'b0, 1'b0, 1'b1, 16'h0000};
		tick;
		chk(pc, 16'h1235);
		step(OP_POPCC, DST_NONE, 1'b0, 8'h00, 8'h13);
		chk(flags, 16'h00F3);
		clk_en = 1'b0;
		step(OP_RCF, DST_NONE, 1'b0, 8'h00, 8'h00);
		chk(flags[0], 1'b1);
		clk_en = 1'b1;
		results();
	end
endmodule
